// *** rtl/ifdr_pkg.sv ***
// Shared constants for the interrupt flag and doze recovery block
package ifdr_pkg;
	// ----------------------------------------
	// Register byte addresses
	// ----------------------------------------
	localparam logic [7:0] REQ_ADDR = 8'h00;
	localparam logic [7:0] DOZE_ADDR = 8'h04;
	localparam logic [7:0] STAT_ADDR = 8'h08;

	// ----------------------------------------
	// Request register layout
	// ----------------------------------------
	localparam int REQ_TIMER_BIT = 0;
	localparam int REQ_CELL_LSB = 4;
	localparam logic [7:0] REQ_IMPL_MASK = 8'hf1;
	localparam logic [7:0] REQ_RESET = 8'h00;

	// ----------------------------------------
	// Doze control register layout
	// ----------------------------------------
	localparam int DOZE_RATIO_LSB = 0;
	localparam int DOZE_ROI_BIT = 4;
	localparam int DOZE_DOE_BIT = 5;
	localparam int DOZE_ACT_BIT = 6;
	localparam logic [2:0] RATIO_RESET = 3'h0;

	// ----------------------------------------
	// Status register layout
	// ----------------------------------------
	localparam int STAT_CYC_BIT = 0;
	localparam int STAT_BUSY_BIT = 1;

	// ----------------------------------------
	// Bus answers
	// ----------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Interrupt entry sequence
	typedef enum logic [1:0] {IFDR_IDLE, IFDR_FINISH, IFDR_VECTOR} ifdr_state_t;
endpackage : ifdr_pkg

// *** rtl/ifdr_top.sv ***
// Peripheral interrupt request flags with doze slowdown and interrupt recovery
// What this block does
// - Each peripheral condition sets its flag in the request register.
// - Flags set whatever the state of any individual or global interrupt enable.
// - Bits 7..4 flag logic cells 4..1, bit 0 flags timer gate done, bits 3..1 read zero, flags stay until software clears.
// - An interrupt with recovery off runs the service routine at the doze ratio rate.
// - With recovery off, interrupt latency stretches with the doze ratio.
// - An interrupt with recovery on clears doze active and restores full speed, sampled at the interrupt.
// - On interrupt entry the prefetched instruction completes before the vector sequence.
// - An interrupt return with doze on exit set re-enters doze at the programmed ratio, unless a recovering interrupt is taken in the same cycle.
`timescale 1ns/10ps
module ifdr_top #(
	parameter int RATIO_W = 3 // Doze ratio field width
) (
	input wire logic aclk, // System clock, 100 MHz
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic [7:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write byte enables
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [7:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic [3:0] logic_cell_event, // Cell 4..1 interrupt conditions, index 3 is cell four
	input wire logic timer_gate_done_event, // Timer gate went inactive
	input wire logic interrupt_taken, // Core accepts an interrupt, pulse
	input wire logic interrupt_return_instruction, // Core executes an interrupt return, pulse
	output logic [7:0] request_flags, // Flag image to the core
	output logic doze_active, // Core runs at reduced rate
	output logic cpu_cycle_en, // One pulse per instruction cycle
	output logic vector_start // Pulse: begin the vector sequence
);
	// ----------------------------------------
	// Parameter check
	// ----------------------------------------
	generate
		if (RATIO_W != 3) begin : g_bad_ratio
			$error("ifdr_top: RATIO_W must be 3");
		end
	endgenerate

	// Last count of one instruction cycle, dividing by 2 to the power ratio+1
	function automatic logic [7:0] ifdr_last(input logic [RATIO_W-1:0] r);
		ifdr_last = 8'((9'h002 << r) - 9'h001);
	endfunction : ifdr_last

	logic [RATIO_W-1:0] doze_ratio;
	logic recover_on_interrupt;
	logic doze_on_exit;
	logic [7:0] cyc_count;
	ifdr_pkg::ifdr_state_t state;
	logic [7:0] aw_addr;
	logic aw_full;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic w_full;
	logic wr_fire;
	logic wr_req;
	logic wr_doze;
	logic [7:0] hw_set;
	logic [7:0] next_flags;
	logic recover_now;

	// ----------------------------------------
	// Write channel: address and data latched independently
	// ----------------------------------------
	assign wr_fire = aw_full && w_full && !s_axi_bvalid;
	assign wr_req = wr_fire && (aw_addr == ifdr_pkg::REQ_ADDR) && w_strb[0];
	assign wr_doze = wr_fire && (aw_addr == ifdr_pkg::DOZE_ADDR) && w_strb[0];

	// Address and data holding, ready drops while an item is held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_full <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_full <= 1'b0;
			end
			s_axi_awready <= !aw_full && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready <= !w_full && !(s_axi_wvalid && s_axi_wready);
		end
	end

	// Write response; unmapped addresses answer SLVERR
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= ifdr_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			if (aw_addr == ifdr_pkg::REQ_ADDR || aw_addr == ifdr_pkg::DOZE_ADDR || aw_addr == ifdr_pkg::STAT_ADDR) begin
				s_axi_bresp <= ifdr_pkg::RESP_OKAY;
			end else begin
				s_axi_bresp <= ifdr_pkg::RESP_SLVERR;
			end
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// Request flags
	// ----------------------------------------
	// Events are ORed after the software value, so a same-cycle clear cannot lose one
	always_comb begin
		hw_set = 8'h00;
		hw_set[ifdr_pkg::REQ_CELL_LSB +: 4] = logic_cell_event;
		hw_set[ifdr_pkg::REQ_TIMER_BIT] = timer_gate_done_event;
		next_flags = request_flags;
		if (wr_req) begin
			next_flags = w_data[7:0];
		end
		next_flags = (next_flags | hw_set) & ifdr_pkg::REQ_IMPL_MASK;
	end

	// Flags hold until software writes them to zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			request_flags <= ifdr_pkg::REQ_RESET;
		end else begin
			request_flags <= next_flags;
		end
	end

	// ----------------------------------------
	// Doze control
	// ----------------------------------------
	// Recovery is decided on the value held at the interrupt, not a later one
	assign recover_now = interrupt_taken && (state == ifdr_pkg::IFDR_IDLE) && recover_on_interrupt;

	// Ratio and option bits change only by software
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			doze_ratio <= ifdr_pkg::RATIO_RESET;
			recover_on_interrupt <= 1'b0;
			doze_on_exit <= 1'b0;
		end else if (wr_doze) begin
			doze_ratio <= w_data[ifdr_pkg::DOZE_RATIO_LSB +: RATIO_W];
			recover_on_interrupt <= w_data[ifdr_pkg::DOZE_ROI_BIT];
			doze_on_exit <= w_data[ifdr_pkg::DOZE_DOE_BIT];
		end
	end

	// Hardware events on doze active outrank a software write in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			doze_active <= 1'b0;
		end else if (recover_now) begin
			doze_active <= 1'b0;
		end else if (interrupt_return_instruction && doze_on_exit) begin
			doze_active <= 1'b1;
		end else if (wr_doze) begin
			doze_active <= w_data[ifdr_pkg::DOZE_ACT_BIT];
		end
	end

	// Instruction cycle pacing: every clock at full speed, slowed while dozing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cyc_count <= 8'h00;
			cpu_cycle_en <= 1'b0;
		end else if (!doze_active) begin
			cyc_count <= 8'h00;
			cpu_cycle_en <= 1'b1;
		end else begin
			cpu_cycle_en <= (cyc_count == ifdr_last(doze_ratio));
			cyc_count <= (cyc_count == ifdr_last(doze_ratio)) ? 8'h00 : 8'(cyc_count + 8'h01);
		end
	end

	// ----------------------------------------
	// Interrupt entry sequence
	// ----------------------------------------
	// The prefetched instruction uses one paced cycle, so a dozing core waits longer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ifdr_pkg::IFDR_IDLE;
			vector_start <= 1'b0;
		end else begin
			vector_start <= 1'b0;
			case (state)
				ifdr_pkg::IFDR_IDLE: begin
					if (interrupt_taken) begin
						state <= ifdr_pkg::IFDR_FINISH;
					end
				end
				ifdr_pkg::IFDR_FINISH: begin
					if (cpu_cycle_en) begin
						state <= ifdr_pkg::IFDR_VECTOR;
					end
				end
				ifdr_pkg::IFDR_VECTOR: begin
					vector_start <= 1'b1;
					state <= ifdr_pkg::IFDR_IDLE;
				end
				default: begin
					state <= ifdr_pkg::IFDR_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	// One read at a time; rdata is captured when the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= ifdr_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= ifdr_pkg::RESP_OKAY;
				if (s_axi_araddr == ifdr_pkg::REQ_ADDR) begin
					s_axi_rdata[7:0] <= request_flags;
				end else if (s_axi_araddr == ifdr_pkg::DOZE_ADDR) begin
					s_axi_rdata[ifdr_pkg::DOZE_RATIO_LSB +: RATIO_W] <= doze_ratio;
					s_axi_rdata[ifdr_pkg::DOZE_ROI_BIT] <= recover_on_interrupt;
					s_axi_rdata[ifdr_pkg::DOZE_DOE_BIT] <= doze_on_exit;
					s_axi_rdata[ifdr_pkg::DOZE_ACT_BIT] <= doze_active;
				end else if (s_axi_araddr == ifdr_pkg::STAT_ADDR) begin
					s_axi_rdata[ifdr_pkg::STAT_CYC_BIT] <= cpu_cycle_en;
					s_axi_rdata[ifdr_pkg::STAT_BUSY_BIT] <= (state != ifdr_pkg::IFDR_IDLE);
				end else begin
					s_axi_rresp <= ifdr_pkg::RESP_SLVERR;
				end
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking ifdr_cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_irq_recover;
		interrupt_taken && state == ifdr_pkg::IFDR_IDLE && recover_on_interrupt && doze_active;
	endsequence
	sequence s_irq_slow;
		interrupt_taken && state == ifdr_pkg::IFDR_IDLE && !recover_on_interrupt && doze_active && !wr_doze;
	endsequence

	cell_flag_set_a: assert property (logic_cell_event[3] |=> request_flags[7]) else $error("cell four flag not set");
	timer_flag_set_a: assert property (timer_gate_done_event |=> request_flags[0]) else $error("timer gate flag not set");
	reserved_zero_a: assert property (request_flags[3:1] == 3'h0) else $error("reserved flag bits set");
	flag_hold_a: assert property (request_flags[4] && !wr_req |=> request_flags[4]) else $error("flag dropped without write");
	set_wins_a: assert property (wr_req && !w_data[6] && logic_cell_event[2] |=> request_flags[6]) else $error("clear beat set");
	recover_clear_a: assert property (s_irq_recover |=> !doze_active ##1 cpu_cycle_en) else $error("no full speed recovery");
	ratio_keep_a: assert property ((s_irq_recover and !wr_doze) |=> $stable(doze_ratio)) else $error("ratio changed on recovery");
	slow_keep_a: assert property ((s_irq_slow and !interrupt_return_instruction) |=> doze_active) else $error("doze left without recovery");
	// Every ratio divides by at least two, so a paced cycle is never followed by another
	slow_pace_a: assert property (cpu_cycle_en && doze_active |=> !cpu_cycle_en) else $error("doze pacing too fast");
	prefetch_first_a: assert property (interrupt_taken && state == ifdr_pkg::IFDR_IDLE |=> !vector_start ##1 !vector_start) else $error("vector before prefetch");
	vector_after_a: assert property (state == ifdr_pkg::IFDR_FINISH && cpu_cycle_en |=> ##1 vector_start) else $error("vector missing");
	exit_doze_a: assert property (interrupt_return_instruction && doze_on_exit && !recover_now |=> doze_active) else $error("doze not re-entered");
endmodule : ifdr_top

// *** testbench/ifdr_core_model.sv ***
// Processor core model: interrupt entry and return pulses, entry timing
`timescale 1ns/10ps
module ifdr_core_model (
	input wire logic aclk, // System clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic req_irq, // Bench asks for an interrupt
	input wire logic req_ret, // Bench asks for an interrupt return
	input wire logic vector_start, // Vector sequence begins
	output logic interrupt_taken, // Entry pulse to the block
	output logic interrupt_return_instruction, // Return pulse to the block
	output logic busy, // Entry under way
	output logic [15:0] latency // Edges from take to vector start
);
	// Pulses last one cycle because the bench requests for one cycle only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			interrupt_taken <= 1'b0;
			interrupt_return_instruction <= 1'b0;
		end else begin
			interrupt_taken <= req_irq;
			interrupt_return_instruction <= req_ret;
		end
	end
	// Time the entry; busy keeps the bench from reading a half count
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy <= 1'b0;
			latency <= 16'h0000;
		end else if (interrupt_taken) begin
			busy <= 1'b1;
			latency <= 16'h0001;
		end else if (busy && vector_start) begin
			busy <= 1'b0;
		end else if (busy) begin
			latency <= latency + 16'h0001;
		end
	end
endmodule : ifdr_core_model

// *** testbench/ifdr_top_bench.sv ***
// Self-checking bench for the interrupt flag and doze recovery block
`timescale 1ns/10ps
module ifdr_top_bench;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, timer_gate_done_event, req_irq, req_ret;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, busy;
	logic doze_active, cpu_cycle_en, vector_start, interrupt_taken, interrupt_return_instruction;
	logic [7:0] s_axi_awaddr, s_axi_araddr, request_flags, acc;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb, logic_cell_event;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [15:0] latency, l0, lat;
	int bad_count, num_checks, n;
	ifdr_top #(.RATIO_W(3)) ifdr_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1),
		.logic_cell_event(logic_cell_event), .timer_gate_done_event(timer_gate_done_event),
		.interrupt_taken(interrupt_taken), .interrupt_return_instruction(interrupt_return_instruction),
		.request_flags(request_flags), .doze_active(doze_active), .cpu_cycle_en(cpu_cycle_en),
		.vector_start(vector_start));
	ifdr_core_model ifdr_core_model_i (.aclk(aclk), .aresetn(aresetn), .req_irq(req_irq), .req_ret(req_ret),
		.vector_start(vector_start), .interrupt_taken(interrupt_taken),
		.interrupt_return_instruction(interrupt_return_instruction), .busy(busy), .latency(latency));
	// Clock at 100 MHz
	always #5 aclk = ~aclk;
	// ----------------------------------------
	// Compare, bus and core tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_range(input logic [15:0] got, input int lo, input int hi);
		num_checks++;
		if ($isunknown(got) || got < lo || got > hi) begin
			bad_count++;
			$display("unexpected at %0t: latency %0d not in %0d..%0d", $time, got, lo, hi);
		end
	endtask : chk_range
	// Both write channels offered together, each released when taken; bready is tied high
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		chk({30'h0000_0000, s_axi_bresp}, {30'h0000_0000, resp});
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		chk(s_axi_rdata, d);
		chk({30'h0000_0000, s_axi_rresp}, {30'h0000_0000, resp});
	endtask : rd
	// One request cycle to the core model, then wait for the vector sequence
	task automatic irq(output logic [15:0] l);
		req_irq <= 1'b1;
		@(posedge aclk);
		req_irq <= 1'b0;
		repeat (2) @(posedge aclk);
		while (busy !== 1'b0) @(posedge aclk);
		l = latency;
	endtask : irq
	task automatic count_cycles;
		n = 0;
		repeat (64) begin
			@(posedge aclk);
			if (cpu_cycle_en === 1'b1) n++;
		end
	endtask : count_cycles
	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : stop_test
	// Watchdog far beyond the few hundred cycles the tests take
	initial begin
		#100000;
		bad_count++;
		stop_test();
	end
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		{aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, timer_gate_done_event, req_irq, req_ret} = 8'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, logic_cell_event} = 52'h0_0000_0000_0000;
		s_axi_wstrb = 4'h1;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(ifdr_pkg::REQ_ADDR, 32'h0000_0000, ifdr_pkg::RESP_OKAY);
		rd(ifdr_pkg::DOZE_ADDR, 32'h0000_0000, ifdr_pkg::RESP_OKAY);
		rd(8'h0c, 32'h0000_0000, ifdr_pkg::RESP_SLVERR);
		rd(ifdr_pkg::STAT_ADDR, 32'h0000_0001, ifdr_pkg::RESP_OKAY);
		// Status writes, unmapped writes and writes without byte 0 must leave every register alone
		wr(ifdr_pkg::STAT_ADDR, 32'h0000_00ff, ifdr_pkg::RESP_OKAY);
		wr(8'h0c, 32'h0000_00ff, ifdr_pkg::RESP_SLVERR);
		s_axi_wstrb <= 4'h0;
		wr(ifdr_pkg::DOZE_ADDR, 32'h0000_0042, ifdr_pkg::RESP_OKAY);
		s_axi_wstrb <= 4'h1;
		rd(ifdr_pkg::DOZE_ADDR, 32'h0000_0000, ifdr_pkg::RESP_OKAY);
		rd(ifdr_pkg::REQ_ADDR, 32'h0000_0000, ifdr_pkg::RESP_OKAY);
		$display("test reset done");
		// Stale flags cleared first; every source then sets its own bit with nothing enabled
		wr(ifdr_pkg::REQ_ADDR, 32'h0000_0000, ifdr_pkg::RESP_OKAY);
		acc = 8'h00;
		for (int i = 0; i < 5; i++) begin
			if (i < 4) logic_cell_event <= 4'h1 << i;
			else timer_gate_done_event <= 1'b1;
			acc = acc | ((i < 4) ? (8'h10 << i) : 8'h01);
			@(posedge aclk);
			logic_cell_event <= 4'h0;
			timer_gate_done_event <= 1'b0;
			@(posedge aclk);
			chk({24'h00_0000, request_flags}, {24'h00_0000, acc});
		end
		repeat (20) @(posedge aclk);
		rd(ifdr_pkg::REQ_ADDR, 32'h0000_00f1, ifdr_pkg::RESP_OKAY);
		wr(ifdr_pkg::REQ_ADDR, 32'hffff_ffff, ifdr_pkg::RESP_OKAY);
		rd(ifdr_pkg::REQ_ADDR, 32'h0000_00f1, ifdr_pkg::RESP_OKAY);
		// Event held high across the clearing write must survive it
		logic_cell_event <= 4'h8;
		wr(ifdr_pkg::REQ_ADDR, 32'h0000_0000, ifdr_pkg::RESP_OKAY);
		logic_cell_event <= 4'h0;
		@(posedge aclk);
		rd(ifdr_pkg::REQ_ADDR, 32'h0000_0080, ifdr_pkg::RESP_OKAY);
		$display("test flags done");
		irq(l0);
		chk_range(l0, 2, 4);
		// Doze at ratio 2 (one cycle in eight) with recovery off; fire just after a paced cycle
		wr(ifdr_pkg::DOZE_ADDR, 32'h0000_0042, ifdr_pkg::RESP_OKAY);
		count_cycles();
		chk(n, 8);
		do @(posedge aclk); while (cpu_cycle_en !== 1'b1);
		irq(lat);
		chk_range(lat, l0 + 3, l0 + 8);
		chk({31'h0000_0000, doze_active}, 32'h0000_0001);
		$display("test doze entry done");
		// Recovery on: full speed at once, ratio kept, doze back on return
		wr(ifdr_pkg::DOZE_ADDR, 32'h0000_0072, ifdr_pkg::RESP_OKAY);
		irq(lat);
		chk_range(lat, l0, l0 + 2);
		chk({31'h0000_0000, doze_active}, 32'h0000_0000);
		rd(ifdr_pkg::DOZE_ADDR, 32'h0000_0032, ifdr_pkg::RESP_OKAY);
		req_ret <= 1'b1;
		@(posedge aclk);
		req_ret <= 1'b0;
		repeat (2) @(posedge aclk);
		chk({31'h0000_0000, doze_active}, 32'h0000_0001);
		rd(ifdr_pkg::DOZE_ADDR, 32'h0000_0072, ifdr_pkg::RESP_OKAY);
		count_cycles();
		chk(n, 8);
		$display("test recovery done");
		// Reset in mid-run while dozing with flags pending: everything returns to its reset value
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk({31'h0000_0000, doze_active}, 32'h0000_0000);
		rd(ifdr_pkg::REQ_ADDR, 32'h0000_0000, ifdr_pkg::RESP_OKAY);
		rd(ifdr_pkg::DOZE_ADDR, 32'h0000_0000, ifdr_pkg::RESP_OKAY);
		rd(ifdr_pkg::STAT_ADDR, 32'h0000_0001, ifdr_pkg::RESP_OKAY);
		$display("test second reset done");
		stop_test();
	end
endmodule : ifdr_top_bench
